// ==== csf_pkg.sv ====
// Package for the status flag logic: register map, bit positions, op codes and types.
// Assumes a Wishbone classic slave with 32-bit data, one register per aligned word.
package csf_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  CSF_FLAGS_IDX    = 8'hd0;               // Word index; the byte address is four times it
	localparam logic [9:0]  CSF_FLAGS_ADDR   = {CSF_FLAGS_IDX, 2'b00};
	localparam logic [7:0]  CSF_FLAGS_RESET  = 8'h00;
	localparam logic [31:0] CSF_UNMAPPED_RD  = 32'h0000_0000;

	// ****************************************
	// Bit positions of the status word
	// ****************************************
	localparam int CSF_BIT_CARRY    = 7;
	localparam int CSF_BIT_AUX      = 6;
	localparam int CSF_BIT_USER0    = 5;
	localparam int CSF_BIT_BANK_HI  = 4;
	localparam int CSF_BIT_BANK_LO  = 3;
	localparam int CSF_BIT_SIGN_ERR = 2;
	localparam int CSF_BIT_USER1    = 1;
	localparam int CSF_BIT_PARITY   = 0;

	localparam logic [7:0]  CSF_BYTE_MAX     = 8'hff;              // Largest product that fits one byte
	localparam logic [7:0]  CSF_DIV_ZERO     = 8'h00;
	localparam logic [7:0]  CSF_BANK_BYTES   = 8'h08;

	// ****************************************
	// Flag-affecting operations
	// ****************************************
	typedef enum logic [3:0] {
		CSF_OP_NONE       = 4'h0,
		CSF_OP_ADD        = 4'h1,
		CSF_OP_ADD_CARRY  = 4'h2,
		CSF_OP_SUB_BORROW = 4'h3,
		CSF_OP_PRODUCT    = 4'h4,
		CSF_OP_DIV        = 4'h5,
		CSF_OP_DEC_ADJUST = 4'h6,
		CSF_OP_CMP_JUMP   = 4'h7
	} csf_op_t;

	typedef struct packed {
		csf_op_t    op;     // Operation whose result updates the flags
		logic [7:0] a;      // First operand (accumulator)
		logic [7:0] b;      // Second operand
	} csf_alu_req_t;

	typedef struct packed {
		logic [7:0] lo;     // Low result byte
		logic [7:0] hi;     // High result byte (product high, remainder)
	} csf_alu_res_t;

endpackage : csf_pkg

// ==== csf_flags.sv ====
// Status flag logic of the core: flag updates from ALU ops, user flags, bank select, parity.
// Assumes a Wishbone classic master on clk_i, and ALU requests presented one cycle each.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module csf_flags
	import csf_pkg::*;
(
	input  wire logic         clk_i,        // Core clock, 100 MHz
	input  wire logic         rst_i,        // Synchronous reset, active high
	input  wire logic         wb_cyc_i,     // Wishbone cycle
	input  wire logic         wb_stb_i,     // Wishbone strobe
	input  wire logic         wb_we_i,      // Wishbone write enable
	input  wire logic [31:0]  wb_adr_i,     // Wishbone byte address
	input  wire logic [3:0]   wb_sel_i,     // Wishbone byte selects
	input  wire logic [31:0]  wb_dat_i,     // Wishbone write data
	output logic      [31:0]  wb_dat_o,     // Wishbone read data
	output logic              wb_ack_o,     // Wishbone acknowledge
	input  csf_alu_req_t      alu_req_i,    // ALU op and operands, one cycle
	input  wire logic [7:0]   acc_i,        // Accumulator value for parity
	output csf_alu_res_t      alu_res_o,    // Registered ALU result bytes
	output logic      [1:0]   bank_sel_o,   // Selected register bank
	output logic      [7:0]   bank_base_o,  // Internal data address of R0
	output logic      [7:0]   status_o      // Current status word
);

	// ****************************************
	// Arithmetic helpers
	// ****************************************
	function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] y, input logic c);
		add9 = {1'b0, x} + {1'b0, y} + {8'h00, c};
	endfunction

	function automatic logic [4:0] add5(input logic [3:0] x, input logic [3:0] y, input logic c);
		add5 = {1'b0, x} + {1'b0, y} + {4'h0, c};
	endfunction

	function automatic logic [7:0] add7(input logic [6:0] x, input logic [6:0] y, input logic c);
		add7 = {1'b0, x} + {1'b0, y} + {7'h00, c};
	endfunction

	// Carry, aux carry and sign error of x + y + c, above the 8-bit sum.
	// Subtraction passes y and c inverted, so its borrows are the inverted carries,
	// while the sign error stays the xor of the carries out of bits 6 and 7.
	function automatic logic [10:0] sum_flags(input logic [7:0] x, input logic [7:0] y, input logic c);
		logic [8:0] s9;
		logic [4:0] s5;
		logic [7:0] s7;
		s9 = add9(x, y, c);
		s5 = add5(x[3:0], y[3:0], c);
		s7 = add7(x[6:0], y[6:0], c);
		sum_flags = {s9[8], s5[4], s9[8] ^ s7[7], s9[7:0]};
	endfunction

	// Packed BCD correction; the top bit is the carry out of the high digit
	function automatic logic [8:0] dec_adjust(input logic [7:0] x, input logic cy, input logic ac);
		logic [8:0] s;
		logic       c;
		s = {1'b0, x};
		if (ac || (x[3:0] > 4'h9)) begin
			s = add9(x, 8'h06, 1'b0);
		end
		c = cy | s[8];
		if (c || (s[7:4] > 4'h9)) begin
			s = add9(s[7:0], 8'h60, 1'b0);
			c = 1'b1;
		end
		dec_adjust = {c, s[7:0]};
	endfunction

	// Product that no longer fits one byte
	function automatic logic prod_wide(input logic [15:0] p);
		prod_wide = (p > {8'h00, CSF_BYTE_MAX});
	endfunction

	// Word decode of the byte address; the two low bits only pick a lane
	function automatic logic addr_hit(input logic [31:0] a);
		addr_hit = (a[31:2] == {22'h000000, CSF_FLAGS_ADDR[9:2]});
	endfunction

	// Internal data address of R0 in the selected bank
	function automatic logic [7:0] bank_base(input logic [1:0] bank);
		bank_base = CSF_BANK_BYTES * {6'h00, bank};
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;
	logic        req;
	logic        hit;
	logic        bus_wr;

	// A request is taken only while ack is low, so each bus cycle acts once
	assign req    = wb_cyc_i & wb_stb_i & ~ack_r;
	assign hit    = addr_hit(wb_adr_i);
	// Lane 0 holds the whole register; a write without it changes nothing
	assign bus_wr = req & wb_we_i & hit & wb_sel_i[0];

	// ****************************************
	// Operand preparation
	// ****************************************
	logic [7:0]   status_r;
	logic [7:0]   status_nxt;
	csf_alu_res_t res_r;
	csf_alu_res_t res_nxt;
	logic         add_cin;
	logic [10:0]  add_f;
	logic [10:0]  sub_f;
	logic [15:0]  prod;
	logic [8:0]   adj_f;
	logic         div_zero;
	logic [7:0]   quot;
	logic [7:0]   rem;

	// Every candidate is formed each cycle; beyond the add carry in, the op code only selects among them.
	// Costs area, but keeps the flag path one level of muxing deep.
	always_comb begin
		add_cin  = (alu_req_i.op == CSF_OP_ADD_CARRY) ? status_r[CSF_BIT_CARRY] : 1'b0;
		add_f    = sum_flags(alu_req_i.a, alu_req_i.b, add_cin);
		sub_f    = sum_flags(alu_req_i.a, ~alu_req_i.b, ~status_r[CSF_BIT_CARRY]);
		prod     = {8'h00, alu_req_i.a} * {8'h00, alu_req_i.b};
		adj_f    = dec_adjust(alu_req_i.a, status_r[CSF_BIT_CARRY], status_r[CSF_BIT_AUX]);
		div_zero = (alu_req_i.b == CSF_DIV_ZERO);
		// A zero divisor still reaches the divider, but its result is muxed to zero, so no unknown leaks out
		quot     = div_zero ? 8'h00 : (alu_req_i.a / alu_req_i.b);
		rem      = div_zero ? 8'h00 : (alu_req_i.a % alu_req_i.b);
	end

	// ****************************************
	// Status word next value
	// ****************************************
	always_comb begin
		status_nxt = status_r;
		// Software write first; an ALU update in the same cycle wins on its own bits
		if (bus_wr) begin
			status_nxt = wb_dat_i[7:0];
		end
		unique case (alu_req_i.op)
			CSF_OP_ADD, CSF_OP_ADD_CARRY: begin
				status_nxt[CSF_BIT_CARRY]    = add_f[10];
				status_nxt[CSF_BIT_AUX]      = add_f[9];
				status_nxt[CSF_BIT_SIGN_ERR] = add_f[8];
			end

			CSF_OP_SUB_BORROW: begin
				status_nxt[CSF_BIT_CARRY]    = ~sub_f[10];
				status_nxt[CSF_BIT_AUX]      = ~sub_f[9];
				status_nxt[CSF_BIT_SIGN_ERR] = sub_f[8];
			end

			CSF_OP_PRODUCT: begin
				status_nxt[CSF_BIT_CARRY]    = 1'b0;
				status_nxt[CSF_BIT_SIGN_ERR] = prod_wide(prod);
			end

			CSF_OP_DIV: begin
				status_nxt[CSF_BIT_CARRY]    = 1'b0;
				status_nxt[CSF_BIT_SIGN_ERR] = div_zero;
			end

			CSF_OP_DEC_ADJUST: begin
				status_nxt[CSF_BIT_CARRY]    = adj_f[8];
			end

			CSF_OP_CMP_JUMP: begin
				status_nxt[CSF_BIT_CARRY]    = (alu_req_i.a < alu_req_i.b);
			end

			CSF_OP_NONE: begin
			end

			default: begin
			end
		endcase
		// Parity tracks the accumulator every cycle; software cannot write it
		status_nxt[CSF_BIT_PARITY] = ^acc_i;
	end

	// ****************************************
	// ALU result next value
	// ****************************************
	always_comb begin
		res_nxt = res_r;
		unique case (alu_req_i.op)
			CSF_OP_ADD, CSF_OP_ADD_CARRY: begin
				res_nxt.lo = add_f[7:0];
				res_nxt.hi = 8'h00;
			end

			CSF_OP_SUB_BORROW: begin
				res_nxt.lo = sub_f[7:0];
				res_nxt.hi = 8'h00;
			end

			CSF_OP_PRODUCT: begin
				res_nxt.lo = prod[7:0];
				res_nxt.hi = prod[15:8];
			end

			CSF_OP_DIV: begin
				// Results are undefined for a zero divisor; holding them costs nothing
				if (!div_zero) begin
					res_nxt.lo = quot;
					res_nxt.hi = rem;
				end
			end

			CSF_OP_DEC_ADJUST: begin
				res_nxt.lo = adj_f[7:0];
				res_nxt.hi = 8'h00;
			end

			CSF_OP_CMP_JUMP, CSF_OP_NONE: begin
			end

			default: begin
			end
		endcase
	end

	// ****************************************
	// Bus next value
	// ****************************************
	always_comb begin
		ack_nxt  = req;
		rdat_nxt = rdat_r;
		// Read data shows the word as it stood before the taking edge
		if (req) begin
			rdat_nxt = hit ? {24'h000000, status_r} : CSF_UNMAPPED_RD;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_r <= CSF_FLAGS_RESET;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res_r <= '0;
		end else begin
			res_r <= res_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r  <= 1'b0;
			rdat_r <= CSF_UNMAPPED_RD;
		end else begin
			ack_r  <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_ack_o    = ack_r;
	assign wb_dat_o    = rdat_r;
	assign alu_res_o   = res_r;
	assign status_o    = status_r;

	// ****************************************
	// Bank select
	// ****************************************
	// Both outputs come straight from the register, so a bank change is seen
	// by the register file in the cycle after the write that made it
	assign bank_sel_o  = {status_r[CSF_BIT_BANK_HI], status_r[CSF_BIT_BANK_LO]};
	assign bank_base_o = bank_base(bank_sel_o);

endmodule // csf_flags

// ==== csf_flags_checker.sv ====
// Port assertions for the status flag block.
// Assumes csf_pkg is compiled first; bound into every csf_flags.
`timescale 1ns/1ps
module csf_flags_checker
	import csf_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_we_i,
	input wire logic       wb_ack_o,
	input csf_alu_req_t    alu_req_i,
	input wire logic [7:0] acc_i,
	input wire logic [1:0] bank_sel_o,
	input wire logic [7:0] bank_base_o,
	input wire logic [7:0] status_o
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_bank_sel: assert property (bank_sel_o == status_o[4:3])
		else $error("bank select wrong");
	a_bank_base: assert property (bank_base_o == {3'h0, bank_sel_o, 3'h0})
		else $error("bank base wrong");
	// Parity settles one edge after reset, so that edge is skipped
	a_parity_odd: assert property (!$past(rst_i) |-> status_o[0] == ^$past(acc_i))
		else $error("parity wrong");
	a_muldiv_cy: assert property (alu_req_i.op inside {CSF_OP_PRODUCT, CSF_OP_DIV} |=> !status_o[7])
		else $error("carry not cleared");
	a_mul_ov: assert property (alu_req_i.op == CSF_OP_PRODUCT |=>
		status_o[2] == (({8'h00, $past(alu_req_i.a)} * {8'h00, $past(alu_req_i.b)}) > 16'h00ff))
		else $error("product overflow wrong");
	a_cmp_cy: assert property (alu_req_i.op == CSF_OP_CMP_JUMP |=>
		status_o[7] == ($past(alu_req_i.a) < $past(alu_req_i.b)))
		else $error("compare carry wrong");
	a_div_zero: assert property (alu_req_i.op == CSF_OP_DIV && alu_req_i.b == CSF_DIV_ZERO |=> status_o[2])
		else $error("divide by zero missed");
	a_user_hold: assert property (!(wb_cyc_i && wb_stb_i && wb_we_i) |=>
		status_o[5] == $past(status_o[5]) && status_o[1] == $past(status_o[1]))
		else $error("user flag changed");
endmodule // csf_flags_checker

bind csf_flags csf_flags_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .alu_req_i(alu_req_i),
	.acc_i(acc_i), .bank_sel_o(bank_sel_o), .bank_base_o(bank_base_o), .status_o(status_o));

// ==== csf_flags_tb_top.sv ====
// Self-checking bench for the status flag block.
// Assumes csf_pkg, csf_flags and the checker are compiled first.
`timescale 1ns/1ps
module csf_flags_tb_top
	import csf_pkg::*;
();
	logic         clk_i, rst_i, cyc, stb, we, ack;
	logic [31:0]  adr, dat, dat_o, q, t;
	logic [3:0]   sel;
	logic [7:0]   acc, base, flags;
	logic [1:0]   bank;
	csf_alu_req_t req;
	csf_alu_res_t res;
	int           error_cnt, cmp_count, i;
	// Per op: op, a, b, then carry in and expected carry, aux, overflow
	logic [31:0]  tv [13] = '{32'h17f01300, 32'h1ff01600, 32'h20f00a00, 32'h30001600,
		32'h38001300, 32'h41010900, 32'h40f11800, 32'h51000900, 32'h51002800,
		32'h69a00400, 32'h64500c00, 32'h70102400, 32'h70201800};
	// Expected result bytes per op, low byte first; divide by zero and compare keep the last
	logic [15:0]  rv [13] = '{16'h8000, 16'h0000, 16'h1000, 16'hff00, 16'h7f00, 16'h0001,
		16'hff00, 16'hff00, 16'h0800, 16'h0000, 16'ha500, 16'ha500, 16'ha500};

	csf_flags u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .alu_req_i(req), .acc_i(acc), .alu_res_o(res),
		.bank_sel_o(bank), .bank_base_o(base), .status_o(flags));

	// ****
	// Tasks
	// ****
	task summarize();
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled, then release
	task wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		// Ack is looked at mid-cycle, away from the edge that moves it
		do @(negedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		@(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// ****
	// Tests
	// ****
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		repeat (3000) @(posedge clk_i);
		error_cnt++;
		summarize();
	end
	initial begin
		{rst_i, cyc, stb, we, adr, dat, sel, acc} = {1'b1, 79'h0};
		req = '{CSF_OP_NONE, 8'h00, 8'h00};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, CSF_FLAGS_ADDR, 32'h0, 4'hf);
		chk("reset", q, 32'h0);
		for (i = 0; i < 4; i++) begin
			wb(1'b1, CSF_FLAGS_ADDR, i << 3, 4'h1);
			chk("bank", bank, i);
			chk("base", base, i * 8);
		end
		// Parity is read only, so bit 0 of the write is dropped
		wb(1'b1, CSF_FLAGS_ADDR, 32'hff, 4'hf);
		wb(1'b1, CSF_FLAGS_ADDR, 32'h00, 4'he);
		wb(1'b1, 32'h0, 32'h00, 4'hf);
		wb(1'b0, 32'h0, 32'h0, 4'hf);
		chk("unmapped", q, CSF_UNMAPPED_RD);
		wb(1'b0, CSF_FLAGS_ADDR, 32'h0, 4'hf);
		chk("flags rd", q, 32'hfe);
		for (i = 0; i < 13; i++) begin
			t = tv[i];
			wb(1'b1, CSF_FLAGS_ADDR, {24'h0, t[11], 7'h32}, 4'h1);
			@(posedge clk_i);
			req <= '{csf_op_t'(t[31:28]), t[27:20], t[19:12]};
			acc <= t[27:20];
			@(posedge clk_i);
			req.op <= CSF_OP_NONE;
			@(negedge clk_i);
			chk("flags", flags, {t[10:9], 3'b110, t[8], 1'b1, ^t[27:20]});
			chk("result", res, rv[i]);
		end
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("rearm", flags, CSF_FLAGS_RESET);
		summarize();
	end
endmodule // csf_flags_tb_top
